/* File: rtl/mifb_pkg.sv */
/*
  Constants, field layouts and carrier types for the interrupt flag and
  enable bank. Assumes a core that reaches the registers through a
  special-purpose data memory port with a register index.
*/
package mifb_pkg;

  // ==========================================================
  // Register indices
  localparam logic [2:0] REG_EDGE   = 3'h0;
  localparam logic [2:0] REG_PRIM_A = 3'h1;
  localparam logic [2:0] REG_PRIM_B = 3'h2;
  localparam logic [2:0] REG_PRIM_C = 3'h3;
  localparam logic [2:0] REG_MULT_A = 3'h4;
  localparam logic [2:0] REG_MULT_B = 3'h5;
  localparam logic [2:0] REG_MULT_C = 3'h6;

  // ==========================================================
  // Implemented-bit masks and reset value
  localparam logic [7:0] MASK_EDGE   = 8'h0F;
  localparam logic [7:0] MASK_PRIM_A = 8'h7F;
  localparam logic [7:0] MASK_FULL   = 8'hFF;
  localparam logic [7:0] MASK_MULT_A = 8'h33;
  localparam logic [7:0] MASK_MULT_C = 8'h33;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // ==========================================================
  // Field positions
  localparam int GLOBAL_EN_BIT  = 0;
  localparam int PIN0_EDGE_LSB  = 0;
  localparam int PIN1_EDGE_LSB  = 2;
  localparam int FLAG_LSB       = 4;

  // ==========================================================
  // Edge field encodings
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ==========================================================
  // Settling time after wake-up, given in ns and rounded up to cycles of the system clock.
  localparam int SETTLE_NS     = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  // ==========================================================
  // Vector numbers, in priority order (0 is highest).
  localparam int NUM_VEC = 11;
  localparam logic [3:0] VEC_PIN0   = 4'h0;
  localparam logic [3:0] VEC_CMP    = 4'h1;
  localparam logic [3:0] VEC_MULT0  = 4'h2;
  localparam logic [3:0] VEC_MULT1  = 4'h3;
  localparam logic [3:0] VEC_MULT2  = 4'h4;
  localparam logic [3:0] VEC_CONV   = 4'h5;
  localparam logic [3:0] VEC_TB0    = 4'h6;
  localparam logic [3:0] VEC_TB1    = 4'h7;
  localparam logic [3:0] VEC_PIN1   = 4'h8;
  localparam logic [3:0] VEC_SYNC   = 4'h9;
  localparam logic [3:0] VEC_SERIAL = 4'hA;

  // Peripheral event pulses, one cycle each.
  typedef struct packed {
    logic comparator;
    logic converter;
    logic timebase0;
    logic timebase1;
    logic sync_serial;
    logic serial_port;
    logic std_timer_a;
    logic std_timer_p;
    logic compact_timer_a;
    logic compact_timer_p;
    logic periodic_timer_a;
    logic periodic_timer_p;
    logic nvm_write;
    logic low_voltage;
  } mifb_events_t;

  // Register access from the core.
  typedef struct packed {
    logic       wr;
    logic [2:0] idx;
    logic [7:0] wdata;
  } mifb_reg_req_t;

endpackage : mifb_pkg

/* File: rtl/mifb_bank.sv */
/*
  Interrupt request and enable register bank. Holds the flags and enables,
  samples two external pins, selects one vector by fixed priority and
  hands it to the core. Assumes the core takes a vector in the cycle that
  irq_ack pulses, and pulses sleep_enter on entry to sleep or idle.
*/
`timescale 1ns/100ps

module mifb_bank
(
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire mifb_pkg::mifb_reg_req_t reg_req,
  output logic [7:0]                  reg_rdata,
  input  wire mifb_pkg::mifb_events_t events,
  input  wire logic                   pin0_in,
  input  wire logic                   pin1_in,
  input  wire logic                   stack_full,
  input  wire logic                   irq_ack,
  input  wire logic                   sleep_enter,
  input  wire logic                   rx_wake,
  output logic                        irq_req,
  output logic [3:0]                  irq_vector,
  output logic                        wake_up
);

  // ==========================================================
  // Register state
  logic [7:0] edge_q, prim_a_q, prim_b_q, prim_c_q;
  logic [7:0] mult_a_q, mult_b_q, mult_c_q;
  logic [1:0] pin0_sync_q, pin1_sync_q;
  logic       pin0_last_q, pin1_last_q;
  logic       sleep_q;
  logic       settle_busy_q;
  logic       serial_hold_q;
  logic [15:0] settle_cnt_q;

  // Edge decode for one external pin.
  function automatic logic edge_hit(input logic [1:0] mode,
                                    input logic       now,
                                    input logic       last);
    logic rise;
    logic fall;
    rise = now & ~last;
    fall = ~now & last;
    unique case (mode)
      mifb_pkg::EDGE_OFF:  edge_hit = 1'b0;
      mifb_pkg::EDGE_RISE: edge_hit = rise;
      mifb_pkg::EDGE_FALL: edge_hit = fall;
      mifb_pkg::EDGE_BOTH: edge_hit = rise | fall;
    endcase
  endfunction : edge_hit

  // Next value of a flag bank: event set beats software write or clear.
  function automatic logic [7:0] upd(input logic [7:0] cur,
                                     input logic       wr,
                                     input logic [7:0] wd,
                                     input logic [7:0] setv,
                                     input logic [7:0] clrv,
                                     input logic [7:0] mask);
    logic [7:0] v;
    v = wr ? wd : cur;
    v = v & ~clrv;
    upd = (v | setv) & mask;
  endfunction : upd

  // ==========================================================
  // Pin synchronisers; only the second stage is examined.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pin0_sync_q <= 2'h0;
      pin0_last_q <= 1'b0;
    end
    else
    begin
      pin0_sync_q <= {pin0_sync_q[0], pin0_in};
      pin0_last_q <= pin0_sync_q[1];
    end
  end

  // Pin 1 has its own chain, so the two pins never share a stage.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pin1_sync_q <= 2'h0;
      pin1_last_q <= 1'b0;
    end
    else
    begin
      pin1_sync_q <= {pin1_sync_q[0], pin1_in};
      pin1_last_q <= pin1_sync_q[1];
    end
  end

  logic pin0_hit, pin1_hit;
  // Edge fields select the trigger; pin 1 uses the upper pair.
  assign pin0_hit = edge_hit(edge_q[mifb_pkg::PIN0_EDGE_LSB +: 2],
                             pin0_sync_q[1], pin0_last_q);
  assign pin1_hit = edge_hit(edge_q[mifb_pkg::PIN1_EDGE_LSB +: 2],
                             pin1_sync_q[1], pin1_last_q);

  // ==========================================================
  // Wake settling: the serial flag from a receive-pin wake is held back until it ends.
  // Sleep ends on the first wake, so a second wake cannot restart it.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      settle_busy_q <= 1'b0;
      settle_cnt_q  <= 16'h0000;
      serial_hold_q <= 1'b0;
    end
    else if (rx_wake && sleep_q)
    begin
      settle_busy_q <= 1'b1;
      settle_cnt_q  <= 16'(mifb_pkg::SETTLE_CYCLES - 1);
      serial_hold_q <= 1'b1;
    end
    else if (settle_busy_q)
    begin
      if (settle_cnt_q == 16'h0000)
        settle_busy_q <= 1'b0;
      else
        settle_cnt_q <= settle_cnt_q - 16'h0001;
    end
    else
    begin
      serial_hold_q <= 1'b0;
    end
  end

  logic serial_wake_set;
  // The flag is raised only once settling ends; enables gate delivery.
  assign serial_wake_set = serial_hold_q & ~settle_busy_q;

  // ==========================================================
  // Priority selection over enabled flags.
  logic [mifb_pkg::NUM_VEC-1:0] pend;
  always_comb
  begin
    pend[mifb_pkg::VEC_PIN0]   = prim_a_q[4] & prim_a_q[1];
    pend[mifb_pkg::VEC_CMP]    = prim_a_q[5] & prim_a_q[2];
    pend[mifb_pkg::VEC_MULT0]  = prim_a_q[6] & prim_a_q[3];
    pend[mifb_pkg::VEC_MULT1]  = prim_b_q[4] & prim_b_q[0];
    pend[mifb_pkg::VEC_MULT2]  = prim_b_q[5] & prim_b_q[1];
    pend[mifb_pkg::VEC_CONV]   = prim_b_q[6] & prim_b_q[2];
    pend[mifb_pkg::VEC_TB0]    = prim_b_q[7] & prim_b_q[3];
    pend[mifb_pkg::VEC_TB1]    = prim_c_q[4] & prim_c_q[0];
    pend[mifb_pkg::VEC_PIN1]   = prim_c_q[5] & prim_c_q[1];
    pend[mifb_pkg::VEC_SYNC]   = prim_c_q[6] & prim_c_q[2];
    pend[mifb_pkg::VEC_SERIAL] = prim_c_q[7] & prim_c_q[3];
  end

  logic [3:0] win;
  logic       any;
  // Lowest index wins; the others stay pending.
  always_comb
  begin
    win = 4'h0;
    any = 1'b0;
    for (int i = mifb_pkg::NUM_VEC - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        win = 4'(i);
        any = 1'b1;
      end
    end
  end

  // A full stack or a clear global enable blocks every acknowledge.
  assign irq_req = any & prim_a_q[mifb_pkg::GLOBAL_EN_BIT]
                   & ~stack_full;
  assign irq_vector = win;

  logic taken;
  assign taken = irq_req & irq_ack;

  // ==========================================================
  // Register write and event capture.
  logic wr_e, wr_a, wr_b, wr_c, wr_ma, wr_mb, wr_mc;
  assign wr_e  = reg_req.wr && reg_req.idx == mifb_pkg::REG_EDGE;
  assign wr_a  = reg_req.wr && reg_req.idx == mifb_pkg::REG_PRIM_A;
  assign wr_b  = reg_req.wr && reg_req.idx == mifb_pkg::REG_PRIM_B;
  assign wr_c  = reg_req.wr && reg_req.idx == mifb_pkg::REG_PRIM_C;
  assign wr_ma = reg_req.wr && reg_req.idx == mifb_pkg::REG_MULT_A;
  assign wr_mb = reg_req.wr && reg_req.idx == mifb_pkg::REG_MULT_B;
  assign wr_mc = reg_req.wr && reg_req.idx == mifb_pkg::REG_MULT_C;

  logic [7:0] set_a, set_b, set_c, clr_a, clr_b, clr_c;
  logic       mult0_any, mult1_any, mult2_any;
  // Multi flags summarise their sub-flags with the sub-enables.
  assign mult0_any = |(mult_a_q[5:4] & mult_a_q[1:0]);
  assign mult1_any = |(mult_b_q[7:4] & mult_b_q[3:0]);
  assign mult2_any = |(mult_c_q[5:4] & mult_c_q[1:0]);

  always_comb
  begin
    set_a = {1'b0, mult0_any, events.comparator, pin0_hit, 4'h0};
    set_b = {events.timebase0, events.converter, mult2_any,
             mult1_any, 4'h0};
    set_c = {events.serial_port | serial_wake_set, events.sync_serial,
             pin1_hit, events.timebase1, 4'h0};
    clr_a = 8'h00;
    clr_b = 8'h00;
    clr_c = 8'h00;
    // Service entry clears the global enable and the served flag; a multi flag stays set while an enabled sub-flag pends.
    if (taken)
    begin
      clr_a[mifb_pkg::GLOBAL_EN_BIT] = 1'b1;
      unique case (win)
        mifb_pkg::VEC_PIN0:   clr_a[4] = 1'b1;
        mifb_pkg::VEC_CMP:    clr_a[5] = 1'b1;
        mifb_pkg::VEC_MULT0:  clr_a[6] = 1'b1;
        mifb_pkg::VEC_MULT1:  clr_b[4] = 1'b1;
        mifb_pkg::VEC_MULT2:  clr_b[5] = 1'b1;
        mifb_pkg::VEC_CONV:   clr_b[6] = 1'b1;
        mifb_pkg::VEC_TB0:    clr_b[7] = 1'b1;
        mifb_pkg::VEC_TB1:    clr_c[4] = 1'b1;
        mifb_pkg::VEC_PIN1:   clr_c[5] = 1'b1;
        mifb_pkg::VEC_SYNC:   clr_c[6] = 1'b1;
        mifb_pkg::VEC_SERIAL: clr_c[7] = 1'b1;
        default:              clr_c = 8'h00;
      endcase
    end
  end

  // The edge register holds no flags, so only software changes it.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      edge_q <= mifb_pkg::RESET_VALUE;
    else
      edge_q <= upd(edge_q, wr_e, reg_req.wdata, 8'h00, 8'h00,
                    mifb_pkg::MASK_EDGE);
  end

  // Flags may be written by software; a same-cycle event still wins.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      prim_a_q <= mifb_pkg::RESET_VALUE;
      prim_b_q <= mifb_pkg::RESET_VALUE;
      prim_c_q <= mifb_pkg::RESET_VALUE;
    end
    else
    begin
      prim_a_q <= upd(prim_a_q, wr_a, reg_req.wdata, set_a, clr_a,
                      mifb_pkg::MASK_PRIM_A);
      prim_b_q <= upd(prim_b_q, wr_b, reg_req.wdata, set_b, clr_b,
                      mifb_pkg::MASK_FULL);
      prim_c_q <= upd(prim_c_q, wr_c, reg_req.wdata, set_c, clr_c,
                      mifb_pkg::MASK_FULL);
    end
  end

  // Sub-flags are never cleared by service; software must clear them.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mult_a_q <= mifb_pkg::RESET_VALUE;
      mult_b_q <= mifb_pkg::RESET_VALUE;
      mult_c_q <= mifb_pkg::RESET_VALUE;
    end
    else
    begin
      mult_a_q <= upd(mult_a_q, wr_ma, reg_req.wdata,
                      {2'h0, events.std_timer_a, events.std_timer_p, 4'h0},
                      8'h00, mifb_pkg::MASK_MULT_A);
      mult_b_q <= upd(mult_b_q, wr_mb, reg_req.wdata,
                      {events.compact_timer_a, events.compact_timer_p,
                       events.periodic_timer_a, events.periodic_timer_p,
                       4'h0}, 8'h00, mifb_pkg::MASK_FULL);
      mult_c_q <= upd(mult_c_q, wr_mc, reg_req.wdata,
                      {2'h0, events.nvm_write, events.low_voltage, 4'h0},
                      8'h00, mifb_pkg::MASK_MULT_C);
    end
  end

  // ==========================================================
  // Sleep tracking and wake on newly set flags or a receive-pin wake.
  logic [7:0] new_a, new_b, new_c, new_ma, new_mb, new_mc;
  assign new_a  = set_a  & ~prim_a_q;
  assign new_b  = set_b  & ~prim_b_q;
  assign new_c  = set_c  & ~prim_c_q;
  assign new_ma = {2'h0, events.std_timer_a, events.std_timer_p, 4'h0}
                  & ~mult_a_q;
  assign new_mb = {events.compact_timer_a, events.compact_timer_p,
                   events.periodic_timer_a, events.periodic_timer_p, 4'h0}
                  & ~mult_b_q;
  assign new_mc = {2'h0, events.nvm_write, events.low_voltage, 4'h0}
                  & ~mult_c_q;

  logic new_flag;
  assign new_flag = |{new_a, new_b, new_c, new_ma, new_mb, new_mc};

  // Sleep is entered on the strobe and left on a new flag or a wake.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      sleep_q <= 1'b0;
    else if (sleep_enter)
      sleep_q <= 1'b1;
    else if (new_flag || rx_wake)
      sleep_q <= 1'b0;
  end

  // A receive-pin wake wakes even with enables clear.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      wake_up <= 1'b0;
    else
      wake_up <= sleep_q & (new_flag | rx_wake);
  end

  // ==========================================================
  // Read-back; unimplemented bits are zero by the masks.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else
    begin
      unique case (reg_req.idx)
        mifb_pkg::REG_EDGE:   reg_rdata <= edge_q;
        mifb_pkg::REG_PRIM_A: reg_rdata <= prim_a_q;
        mifb_pkg::REG_PRIM_B: reg_rdata <= prim_b_q;
        mifb_pkg::REG_PRIM_C: reg_rdata <= prim_c_q;
        mifb_pkg::REG_MULT_A: reg_rdata <= mult_a_q;
        mifb_pkg::REG_MULT_B: reg_rdata <= mult_b_q;
        mifb_pkg::REG_MULT_C: reg_rdata <= mult_c_q;
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule : mifb_bank

/* File: testbench/mifb_bank_assertions.sv */
/*
  Port checker for the interrupt flag and enable bank.
  Assumes reg_rdata shows the register indexed at the previous edge.
*/
`timescale 1ns/100ps

module mifb_bank_assertions
(
  input wire logic                    mclk,
  input wire logic                    sys_rst,
  input wire mifb_pkg::mifb_reg_req_t reg_req,
  input wire logic [7:0]              reg_rdata,
  input wire mifb_pkg::mifb_events_t  events,
  input wire logic                    stack_full,
  input wire logic                    irq_ack,
  input wire logic                    irq_req
);
  // ======================================================
  // Sequences
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // A write that is followed by a read of the same register.
  sequence s_wr_sel(logic [2:0] i);
    reg_req.wr && reg_req.idx == i ##1 reg_req.idx == i;
  endsequence

  // A converter event, then the core selecting its flag register the next cycle.
  sequence s_conv_sel;
    events.converter ##1 reg_req.idx == mifb_pkg::REG_PRIM_B;
  endsequence

  // ======================================================
  // Properties
  property p_stack_block;
    stack_full |-> !irq_req;
  endproperty
  a_stack_block: assert property (p_stack_block)
    else $error("request raised while stack full");

  property p_global_off;
    reg_req.wr && reg_req.idx == mifb_pkg::REG_PRIM_A
      && !reg_req.wdata[0] |=> !irq_req;
  endproperty
  a_global_off: assert property (p_global_off)
    else $error("request raised with global enable clear");

  // A write to the enable register in the ack cycle cannot re-arm it; the service clear wins.
  property p_ack_clear;
    irq_req && irq_ack
      && !(reg_req.wr && reg_req.idx == mifb_pkg::REG_PRIM_A) |=> !irq_req;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("request still raised after acknowledge");

  property p_conv_flag;
    s_conv_sel |=> reg_rdata[6];
  endproperty
  a_conv_flag: assert property (p_conv_flag)
    else $error("converter flag not recorded");

  property p_edge_hi;
    reg_req.idx == mifb_pkg::REG_EDGE |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_edge_hi: assert property (p_edge_hi)
    else $error("edge register upper bits not zero");

  property p_mult_a;
    reg_req.idx == mifb_pkg::REG_MULT_A
      |=> (reg_rdata & ~mifb_pkg::MASK_MULT_A) == 8'h00;
  endproperty
  a_mult_a: assert property (p_mult_a)
    else $error("multi register A spare bits not zero");

  property p_prim_a;
    reg_req.idx == mifb_pkg::REG_PRIM_A |=> !reg_rdata[7];
  endproperty
  a_prim_a: assert property (p_prim_a)
    else $error("primary register A bit 7 not zero");

  property p_prim_c_rw;
    s_wr_sel(mifb_pkg::REG_PRIM_C)
      |=> reg_rdata[3:0] == $past(reg_req.wdata[3:0], 2);
  endproperty
  a_prim_c_rw: assert property (p_prim_c_rw)
    else $error("primary register C enables not kept");

  property p_edge_rw;
    s_wr_sel(mifb_pkg::REG_EDGE)
      |=> reg_rdata[3:0] == $past(reg_req.wdata[3:0], 2);
  endproperty
  a_edge_rw: assert property (p_edge_rw)
    else $error("edge fields not kept");
endmodule : mifb_bank_assertions

bind mifb_bank mifb_bank_assertions chk_u
(
  .mclk       (mclk),
  .sys_rst    (sys_rst),
  .reg_req    (reg_req),
  .reg_rdata  (reg_rdata),
  .events     (events),
  .stack_full (stack_full),
  .irq_ack    (irq_ack),
  .irq_req    (irq_req)
);

/* File: testbench/mifb_core_model.sv */
/*
  Core model that takes interrupt vectors, promptly or after a stall.
  Assumes the bank raises irq_req as a level until acknowledged.
*/
`timescale 1ns/100ps

module mifb_core_model
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       respond,
  input  wire logic [3:0] stall,
  input  wire logic       irq_req,
  input  wire logic [3:0] irq_vector,
  output logic            irq_ack,
  output logic [3:0]      taken_vec,
  output int              taken_cnt
);
  int wait_cnt;

  // Ack is a one-cycle pulse; a gap follows so one request is taken once.
  always @(negedge mclk)
  begin
    if (sys_rst || !respond || !irq_req || irq_ack)
    begin
      irq_ack  <= 1'b0;
      wait_cnt <= 0;
    end
    else if (wait_cnt < int'(stall))
    begin
      irq_ack  <= 1'b0;
      wait_cnt <= wait_cnt + 1;
    end
    else
      irq_ack <= 1'b1;
  end

  // Record each vector at the edge where the bank takes the ack.
  always @(posedge mclk)
    if (sys_rst)
      taken_cnt <= 0;
    else if (irq_req && irq_ack)
    begin
      taken_vec <= irq_vector;
      taken_cnt <= taken_cnt + 1;
    end
endmodule : mifb_core_model

/* File: testbench/mcu_interrupt_flag_enable_bank_tb_top.sv */
/*
  Self-checking bench for the interrupt flag and enable bank.
  Assumes the package, the bank, the checker and the core model compile first.
*/
`timescale 1ns/100ps

module mcu_interrupt_flag_enable_bank_tb_top;
  logic                    mclk        = 1'b0;
  logic                    sys_rst     = 1'b1;
  mifb_pkg::mifb_reg_req_t reg_req     = '0;
  mifb_pkg::mifb_events_t  events      = '0;
  logic                    pin0_in     = 1'b0;
  logic                    pin1_in     = 1'b0;
  logic                    stack_full  = 1'b0;
  logic                    sleep_enter = 1'b0;
  logic                    rx_wake     = 1'b0;
  logic                    respond     = 1'b0;
  logic [3:0]              stall       = 4'h0;
  logic [7:0]              reg_rdata;
  logic [3:0]              irq_vector, taken_vec;
  logic                    irq_req, irq_ack, wake_up;
  int                      core_taken;
  int                      wake_cnt    = 0;
  int                      err_count   = 0;
  int                      checks_done = 0;

  // ======================================================
  // Clock, design and core
  initial
  begin
    forever #5 mclk = ~mclk;
  end

  mifb_bank dut_u
  (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .reg_req     (reg_req),
    .reg_rdata   (reg_rdata),
    .events      (events),
    .pin0_in     (pin0_in),
    .pin1_in     (pin1_in),
    .stack_full  (stack_full),
    .irq_ack     (irq_ack),
    .sleep_enter (sleep_enter),
    .rx_wake     (rx_wake),
    .irq_req     (irq_req),
    .irq_vector  (irq_vector),
    .wake_up     (wake_up)
  );

  mifb_core_model core_u
  (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .respond    (respond),
    .stall      (stall),
    .irq_req    (irq_req),
    .irq_vector (irq_vector),
    .irq_ack    (irq_ack),
    .taken_vec  (taken_vec),
    .taken_cnt  (core_taken)
  );

  // Wake pulses last one cycle, so they are counted rather than polled.
  always @(posedge mclk)
    if (wake_up === 1'b1)
      wake_cnt <= wake_cnt + 1;

  // ======================================================
  // Shared tasks
  task automatic check(string what, logic [7:0] seen, logic [7:0] want);
    checks_done++;
    if (seen !== want)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic wr(logic [2:0] i, logic [7:0] d);
    @(negedge mclk);
    reg_req <= '{1'b1, i, d};
    @(negedge mclk);
    reg_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [2:0] i, output logic [7:0] d);
    @(negedge mclk);
    reg_req.idx <= i;
    @(negedge mclk);
    d = reg_rdata;
  endtask : rd

  task automatic expect_reg(logic [2:0] i, logic [7:0] want);
    logic [7:0] d;
    rd(i, d);
    check($sformatf("reg%0d", i), d, want);
  endtask : expect_reg

  task automatic pulse(mifb_pkg::mifb_events_t e);
    @(negedge mclk);
    events <= e;
    @(negedge mclk);
    events <= '0;
  endtask : pulse

  task automatic strobe(logic s_en, logic rx);
    @(negedge mclk);
    sleep_enter <= s_en;
    rx_wake     <= rx;
    @(negedge mclk);
    sleep_enter <= 1'b0;
    rx_wake     <= 1'b0;
  endtask : strobe

  // Bounded wait, since a lost ack would otherwise hang the scenario.
  task automatic wait_taken(int n);
    for (int k = 0; k < 50 && core_taken < n; k++)
      @(negedge mclk);
    check("taken", 8'(core_taken), 8'(n));
  endtask : wait_taken

  // ======================================================
  // Scenarios
  task automatic t_masks();
    logic [7:0] m [8];
    m = '{8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'h33, 8'h00};
    for (int i = 0; i < 8; i++)
      expect_reg(3'(i), 8'h00);
    for (int i = 0; i < 8; i++)
      wr(3'(i), 8'hFF);
    for (int i = 0; i < 8; i++)
      expect_reg(3'(i), m[i]);
    for (int i = 7; i >= 0; i--)
      wr(3'(i), 8'h00);
    for (int i = 0; i < 8; i++)
      expect_reg(3'(i), 8'h00);
  endtask : t_masks

  task automatic t_edges();
    logic [7:0] d;
    logic [1:0] code;
    logic       got, want;
    for (int n = 0; n < 8; n++)
    begin
      code = n[1:0];
      wr(3'h0, n[2] ? {4'h0, code, 2'h0} : {6'h00, code});
      for (int lvl = 1; lvl >= 0; lvl--)
      begin
        if (n[2])
          pin1_in <= lvl[0];
        else
          pin0_in <= lvl[0];
        repeat (4) @(negedge mclk);
        rd(n[2] ? 3'h3 : 3'h1, d);
        got  = n[2] ? d[5] : d[4];
        want = lvl[0] ? code[0] : code[1];
        check("pin_flag", {7'h00, got}, {7'h00, want});
        wr(n[2] ? 3'h3 : 3'h1, 8'h00);
      end
    end
  endtask : t_edges

  task automatic t_priority();
    mifb_pkg::mifb_events_t e;
    e            = '0;
    e.comparator = 1'b1;
    e.converter  = 1'b1;
    wr(3'h1, 8'h04);
    wr(3'h2, 8'h04);
    expect_reg(3'h2, 8'h04);
    pulse(e);
    expect_reg(3'h2, 8'h44);
    expect_reg(3'h1, 8'h24);
    wr(3'h1, 8'h25);
    check("vector", {4'h0, irq_vector}, {4'h0, mifb_pkg::VEC_CMP});
    stack_full <= 1'b1;
    @(negedge mclk);
    check("stack", {7'h00, irq_req}, 8'h00);
    stack_full <= 1'b0;
    respond    <= 1'b1;
    wait_taken(1);
    check("taken_vec", {4'h0, taken_vec}, {4'h0, mifb_pkg::VEC_CMP});
    expect_reg(3'h1, 8'h04);
    stall <= 4'h3;
    wr(3'h1, 8'h05);
    wait_taken(2);
    check("taken_vec", {4'h0, taken_vec}, {4'h0, mifb_pkg::VEC_CONV});
    expect_reg(3'h2, 8'h04);
    respond <= 1'b0;
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h00);
  endtask : t_priority

  // Sub-flags summarise into primary flags only through their enables.
  task automatic t_multi();
    mifb_pkg::mifb_events_t e;
    e                 = '0;
    e.std_timer_a     = 1'b1;
    e.compact_timer_p = 1'b1;
    e.low_voltage     = 1'b1;
    wr(3'h4, 8'h02);
    pulse(e);
    expect_reg(3'h4, 8'h22);
    expect_reg(3'h5, 8'h40);
    expect_reg(3'h6, 8'h10);
    expect_reg(3'h1, 8'h40);
    for (int i = 6; i >= 1; i--)
      wr(3'(i), 8'h00);
    expect_reg(3'h1, 8'h00);
  endtask : t_multi

  task automatic t_wake();
    int                     n;
    logic                   ok;
    mifb_pkg::mifb_events_t e;
    e           = '0;
    e.timebase0 = 1'b1;
    strobe(1'b1, 1'b0);
    pulse(e);
    repeat (3) @(negedge mclk);
    check("wake", 8'(wake_cnt), 8'h01);
    strobe(1'b1, 1'b0);
    strobe(1'b0, 1'b1);
    repeat (mifb_pkg::SETTLE_CYCLES + 8) @(negedge mclk);
    check("wake", 8'(wake_cnt), 8'h02);
    check("quiet", {7'h00, irq_req}, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h08);
    wr(3'h1, 8'h01);
    strobe(1'b1, 1'b0);
    strobe(1'b0, 1'b1);
    for (n = 0; n < 300 && irq_req !== 1'b1; n++)
      @(negedge mclk);
    ok = n >= mifb_pkg::SETTLE_CYCLES - 3 && n <= mifb_pkg::SETTLE_CYCLES + 3;
    check("settle", {7'h00, ok}, 8'h01);
    check("vector", {4'h0, irq_vector}, {4'h0, mifb_pkg::VEC_SERIAL});
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h00);
  endtask : t_wake

  // ======================================================
  // Sequence, watchdog and verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (12) @(negedge mclk);
    sys_rst <= 1'b0;
    t_masks();
    t_edges();
    t_priority();
    t_multi();
    t_wake();
    complete_run();
  end

  // The scenarios need about 530 cycles; this leaves a wide margin.
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    complete_run();
  end
endmodule : mcu_interrupt_flag_enable_bank_tb_top
